// [macro_entry_point_mapper_bench.sv]
// self-checking bench for the macro entry point mapper
`timescale 1ns/10ps
`default_nettype none
module macro_entry_point_mapper_bench;
	logic clk, rst_n, map_req, jx, b12, b17, eop, adr;
	logic [15:0] ir, sbus_in;
	logic [7:0] tgt;
	logic [2:0] mods;
	wire logic [15:0] sbus;
	wire logic [9:0] cs_addr, rom_tgt;
	wire logic hit, pa;
	int bad_count, tests_run;
	mep_mapper i_mep_mapper (.REF_CLK(clk), .RST_N(rst_n), .IR(ir),
		.MAP_REQ(map_req), .JUMP_EXEC(jx), .JUMP_TARGET_BITS(tgt),
		.JUMP_BIT12(b12), .JUMP_BIT17(b17), .END_OF_PHASE(eop),
		.ADR_SELECT(adr), .SBUS_IN(sbus_in), .SBUS(sbus),
		.MOD_PRESENT(mods), .CS_ADDR(cs_addr), .MAP_HIT(hit),
		.PHASE_ADVANCE(pa));
	mep_rom_model i_mep_rom_model (.ADDR(cs_addr), .TARGET(rom_tgt));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task print_verdict;
		$display("errors %0d in %0d checks", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	task cyc;
		@(posedge clk);
		@(negedge clk);
	endtask
	task rst(input logic [2:0] m);
		mods = m;
		rst_n = 1'b0;
		repeat (3) cyc;
		rst_n = 1'b1;
		repeat (3) cyc;
	endtask
	task map1(input logic [15:0] v);
		ir = v;
		map_req = 1'b1;
		cyc;
		map_req = 1'b0;
	endtask
	task jump1(input logic [9:0] t, input logic a, input logic [15:0] s);
		{b12, b17, tgt} = t;
		adr = a;
		sbus_in = s;
		jx = 1'b1;
		cyc;
		jx = 1'b0;
		adr = 1'b0;
		sbus_in = 16'h0000;
	endtask
	task t_map(input logic [2:0] m, input logic [1:0] sel);
		int i;
		rst(m);
		map_req = 1'b1;
		for (i = 0; i < 16; i++) begin
			ir = 16'h8A00 + 16'(i * 16);
			cyc;
			chk("cs_addr", {sel, 4'h0, 4'(i)}, cs_addr);
			chk("map_hit", 16'h0001, hit);
		end
		map_req = 1'b0;
		cyc;
		chk("map_hit", 16'h0000, hit);
	endtask
	task t_refuse;
		rst(3'h1);
		map_req = 1'b1;
		ir = 16'h8850;
		cyc;
		chk("map_hit", 16'h0000, hit);
		ir = 16'h9A50;
		cyc;
		chk("map_hit", 16'h0000, hit);
		ir = 16'h8250;
		cyc;
		chk("map_hit", 16'h0000, hit);
		ir = 16'h8E50;
		cyc;
		chk("map_hit", 16'h0000, hit);
		map_req = 1'b0;
		rst(3'h0);
		map1(16'h8A50);
		chk("map_hit", 16'h0000, hit);
	endtask
	task t_jump;
		rst(3'h1);
		map1(16'h8A55);
		chk("cs_addr", 16'h0105, cs_addr);
		adr = 1'b1;
		#1;
		chk("sbus", 16'h0255, sbus);
		jump1(rom_tgt, 1'b1, 16'hFFFF);
		chk("cs_addr", 16'h0115, cs_addr);
		map1(16'h8A63);
		jump1(rom_tgt, 1'b0, 16'hFFF0);
		chk("cs_addr", 16'h0206, cs_addr);
		cyc;
		jump1(10'h000, 1'b0, 16'hFFF0);
		chk("cs_addr", 16'h0000, cs_addr);
		ir = 16'h8AFA;
		map_req = 1'b1;
		cyc;
		jump1(rom_tgt, 1'b0, 16'h0000);
		map_req = 1'b0;
		chk("cs_addr", 16'h030F, cs_addr);
		chk("map_hit", 16'h0000, hit);
	endtask
	task t_tables;
		rst(3'h2);
		map1(16'h8A60);
		jump1(rom_tgt, 1'b0, 16'h0000);
		chk("cs_addr", 16'h0210, cs_addr);
		map1(16'h8AB0);
		jump1(rom_tgt, 1'b0, 16'h0000);
		chk("cs_addr", 16'h030B, cs_addr);
		map1(16'h8A00);
		jump1(rom_tgt, 1'b0, 16'h0000);
		chk("cs_addr", 16'h02F0, cs_addr);
		rst(3'h4);
		map1(16'h8A00);
		jump1(rom_tgt, 1'b0, 16'h0000);
		chk("cs_addr", 16'h03F0, cs_addr);
		map1(16'h8AB0);
		jump1(rom_tgt, 1'b0, 16'h0000);
		chk("cs_addr", 16'h0310, cs_addr);
	endtask
	task t_eop;
		eop = 1'b1;
		cyc;
		eop = 1'b0;
		chk("phase_advance", 16'h0000, pa);
		cyc;
		chk("phase_advance", 16'h0001, pa);
		cyc;
		chk("phase_advance", 16'h0000, pa);
	endtask
	initial begin
		#100000;
		bad_count++;
		print_verdict;
	end
	initial begin
		{rst_n, map_req, jx, b12, b17, eop, adr} = 7'h00;
		{ir, sbus_in, tgt, mods} = 43'h0;
		t_map(3'h7, 2'h1);
		t_map(3'h6, 2'h2);
		t_map(3'h4, 2'h3);
		t_map(3'h5, 2'h1);
		t_refuse;
		t_jump;
		t_tables;
		t_eop;
		print_verdict;
	end
endmodule
`default_nettype wire

// [mep_defines.svh]
// constants and rule summary for the macro entry point mapper
// Operation
// - instruction bits 4-7 form address bits 0-3
// - address bits 9-8 encode selected module
// - lowest installed module above 0 holds entries
// - entries at 400, 1000 or 1400 octal
// - codes 105000 to 105360 map consecutively
// - jump ORs source bus bits 0-3 into target
// - low field select drives instruction bits 0-9
// - only source bus bits 0-3 alter address
// - low instruction bits give 16 secondary entries
// - extension group decoded from bits 15-9
// - ten bit jump address from eight target bits, bit 12 and bit 17
// - end of phase advances after next instruction
`ifndef MEP_DEFINES_SVH
`define MEP_DEFINES_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define MEP_ADDR_W 10
`define MEP_IR_W 16

// ----------------------------------------
// module select codes for address bits 9-8
// ----------------------------------------
`define MEP_SEL_MOD1 2'h1
`define MEP_SEL_MOD2 2'h2
`define MEP_SEL_MOD3 2'h3

// ----------------------------------------
// primary table bases (octal 400, 1000, 1400)
// ----------------------------------------
`define MEP_BASE_MOD1 10'h100
`define MEP_BASE_MOD2 10'h200
`define MEP_BASE_MOD3 10'h300
`define MEP_RESET_ADDR 10'h000

`endif

// [mep_mapper.sv]
// extension group entry point mapper and jump merge path
`timescale 1ns/10ps
`default_nettype none
`include "mep_defines.svh"

module mep_mapper (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// instruction register and sequencer controls
	input wire logic [15:0] IR,
	input wire logic MAP_REQ,
	input wire logic JUMP_EXEC,
	input wire logic [7:0] JUMP_TARGET_BITS,
	input wire logic JUMP_BIT12,
	input wire logic JUMP_BIT17,
	input wire logic END_OF_PHASE,
	// source bus
	input wire logic ADR_SELECT,
	input wire logic [15:0] SBUS_IN,
	output logic [15:0] SBUS,
	// installed modules 1..3, static straps
	input wire logic [2:0] MOD_PRESENT,
	// results
	output logic [9:0] CS_ADDR,
	output logic MAP_HIT,
	output logic PHASE_ADVANCE
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic is_ext(input logic [15:0] ir);
		is_ext = ir[15] & ~ir[14] & ~ir[13] & ~ir[12] & ~ir[10]
			& ir[11] & ir[9];
	endfunction

	function automatic mep_pkg::mep_module_t pick_mod(
			input logic [2:0] pres);
		if (pres[0]) begin
			pick_mod = mep_pkg::MEP_MOD_ONE;
		end else if (pres[1]) begin
			pick_mod = mep_pkg::MEP_MOD_TWO;
		end else if (pres[2]) begin
			pick_mod = mep_pkg::MEP_MOD_THREE;
		end else begin
			pick_mod = mep_pkg::MEP_MOD_NONE;
		end
	endfunction

	function automatic logic [9:0] entry_addr(input logic [15:0] ir,
			input mep_pkg::mep_module_t m);
		logic [1:0] sel;
		sel = `MEP_SEL_MOD1;
		unique case (m)
			mep_pkg::MEP_MOD_ONE: sel = `MEP_SEL_MOD1;
			mep_pkg::MEP_MOD_TWO: sel = `MEP_SEL_MOD2;
			mep_pkg::MEP_MOD_THREE: sel = `MEP_SEL_MOD3;
			mep_pkg::MEP_MOD_NONE: sel = 2'h0;
		endcase
		entry_addr = {sel, 4'h0, ir[7:4]};
	endfunction

	// ----------------------------------------
	// module presence synchroniser
	// ----------------------------------------
	logic [2:0] pres_meta;
	logic [2:0] pres;
	logic [2:0] next_pres_meta;
	logic [2:0] next_pres;

	always_comb begin
		next_pres_meta = MOD_PRESENT;
		next_pres = pres_meta;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pres_meta <= 3'h0;
			pres <= 3'h0;
		end else begin
			pres_meta <= next_pres_meta;
			pres <= next_pres;
		end
	end

	// ----------------------------------------
	// source bus and merge path
	// ----------------------------------------
	mep_pkg::mep_module_t sel_mod;
	logic [9:0] jump_addr;
	logic [3:0] merge_bits;

	always_comb begin
		sel_mod = pick_mod(pres);
		SBUS = ADR_SELECT ? {6'h00, IR[9:0]} : SBUS_IN;
		merge_bits = JUMP_EXEC ? SBUS[3:0] : 4'h0;
		jump_addr = {JUMP_BIT12, JUMP_BIT17, JUMP_TARGET_BITS}
			| {6'h00, merge_bits};
	end

	// ----------------------------------------
	// control store address register
	// ----------------------------------------
	mep_pkg::mep_src_t src;
	logic [9:0] next_cs_addr;
	logic next_map_hit;

	always_comb begin
		next_map_hit = MAP_REQ & ~JUMP_EXEC & is_ext(IR)
			& (sel_mod != mep_pkg::MEP_MOD_NONE);
		if (JUMP_EXEC) begin
			src = mep_pkg::MEP_SRC_JUMP;
		end else if (next_map_hit) begin
			src = mep_pkg::MEP_SRC_MAP;
		end else begin
			src = mep_pkg::MEP_SRC_STEP;
		end
		next_cs_addr = CS_ADDR + 10'h001;
		unique case (src)
			mep_pkg::MEP_SRC_JUMP: next_cs_addr = jump_addr;
			mep_pkg::MEP_SRC_MAP:
				next_cs_addr = entry_addr(IR, sel_mod);
			mep_pkg::MEP_SRC_STEP: next_cs_addr = CS_ADDR + 10'h001;
			default: next_cs_addr = CS_ADDR;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CS_ADDR <= `MEP_RESET_ADDR;
			MAP_HIT <= 1'b0;
		end else begin
			CS_ADDR <= next_cs_addr;
			MAP_HIT <= next_map_hit;
		end
	end

	// ----------------------------------------
	// end of phase
	// ----------------------------------------
	logic eop_pending;
	logic next_eop_pending;
	logic next_phase_advance;

	always_comb begin
		next_eop_pending = END_OF_PHASE;
		next_phase_advance = eop_pending;
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			eop_pending <= 1'b0;
			PHASE_ADVANCE <= 1'b0;
		end else begin
			eop_pending <= next_eop_pending;
			PHASE_ADVANCE <= next_phase_advance;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	chk_low_nibble: assert property (
		MAP_REQ && !JUMP_EXEC && is_ext(IR) && pres != 3'h0
		|=> CS_ADDR[3:0] == $past(IR[7:4]) && CS_ADDR[7:4] == 4'h0)
		else $error("entry low bits do not follow instruction");

	chk_mod_bits: assert property (
		MAP_HIT |-> (CS_ADDR[9:8] == 2'h1 && $past(pres[0]))
		|| (CS_ADDR[9:8] == 2'h2 && $past(pres[1:0]) == 2'h2)
		|| (CS_ADDR[9:8] == 2'h3 && $past(pres) == 3'h4))
		else $error("module bits wrong");

	chk_lowest_mod: assert property (
		MAP_REQ && !JUMP_EXEC && is_ext(IR) && pres == 3'h6
		|=> CS_ADDR >= `MEP_BASE_MOD2 && CS_ADDR < `MEP_BASE_MOD3)
		else $error("lowest module not chosen");

	chk_entry_range: assert property (
		MAP_HIT |-> CS_ADDR[7:4] == 4'h0 && CS_ADDR[9:8] != 2'h0)
		else $error("entry outside primary table");

	chk_code_step: assert property (
		MAP_REQ && !JUMP_EXEC && IR == 16'h8A50 && pres[0]
		|=> CS_ADDR == `MEP_BASE_MOD1 + 10'h005)
		else $error("code 105120 not at 405");

	chk_jump_merge: assert property (
		JUMP_EXEC |=> CS_ADDR == ($past({JUMP_BIT12, JUMP_BIT17,
			JUMP_TARGET_BITS}) | {6'h00, $past(SBUS[3:0])}))
		else $error("jump merge wrong");

	chk_adr_drive: assert property (
		ADR_SELECT |-> SBUS[9:0] == IR[9:0] && SBUS[15:10] == 6'h00)
		else $error("low field not on source bus");

	chk_upper_ignored: assert property (
		JUMP_EXEC && JUMP_TARGET_BITS == 8'h00 && !JUMP_BIT12
		&& !JUMP_BIT17 |=> CS_ADDR[9:4] == 6'h00)
		else $error("upper bus bits leaked");

	chk_idle_zero: assert property (
		JUMP_EXEC && SBUS[3:0] == 4'h0 |=> CS_ADDR == $past({JUMP_BIT12,
			JUMP_BIT17, JUMP_TARGET_BITS}))
		else $error("idle merge not zero");

	chk_phase_adv: assert property (
		END_OF_PHASE |-> ##2 PHASE_ADVANCE)
		else $error("phase did not advance");

	chk_ext_decode: assert property (
		MAP_REQ && !JUMP_EXEC && !IR[11] |=> !MAP_HIT)
		else $error("non extension mapped");

	cov_map_mod1: cover property (MAP_HIT && CS_ADDR[9:8] == 2'h1);
	cov_map_mod3: cover property (MAP_HIT && CS_ADDR[9:8] == 2'h3);
	cov_secondary: cover property (JUMP_EXEC && ADR_SELECT
		&& IR[3:0] != 4'h0);
	cov_eop: cover property (END_OF_PHASE ##2 PHASE_ADVANCE);

endmodule

`default_nettype wire

// [mep_pkg.sv]
// types for the macro entry point mapper
`default_nettype none
package mep_pkg;
	// module chosen to hold the primary entry points
	typedef enum logic [1:0] {
		MEP_MOD_NONE,
		MEP_MOD_ONE,
		MEP_MOD_TWO,
		MEP_MOD_THREE
	} mep_module_t;

	// source of the next control store address
	typedef enum logic [1:0] {
		MEP_SRC_STEP,
		MEP_SRC_MAP,
		MEP_SRC_JUMP
	} mep_src_t;
endpackage
`default_nettype wire

// [mep_rom_model.sv]
// control store stand-in holding the standard primary jump tables
`timescale 1ns/10ps
`default_nettype none
module mep_rom_model (
	// control store address
	input wire logic [9:0] ADDR,
	// jump target held in the word at that address
	output logic [9:0] TARGET
);
	always_comb begin
		if (ADDR <= 10'h105) begin
			TARGET = 10'h110;
		end else if (ADDR <= 10'h10A) begin
			TARGET = ADDR + 10'h100;
		end else if (ADDR <= 10'h10F) begin
			TARGET = ADDR + 10'h200;
		end else if (ADDR >= 10'h200 && ADDR <= 10'h205) begin
			TARGET = 10'h2F0;
		end else if (ADDR >= 10'h206 && ADDR <= 10'h20A) begin
			TARGET = 10'h210;
		end else if (ADDR >= 10'h20B && ADDR <= 10'h20F) begin
			TARGET = ADDR + 10'h100;
		end else if (ADDR >= 10'h300 && ADDR <= 10'h30A) begin
			TARGET = 10'h3F0;
		end else begin
			TARGET = 10'h310;
		end
	end
endmodule
`default_nettype wire
